/* File: shared/acs_pkg.sv */
// Shared constants and types for the converter sequencer
package acs_pkg;
    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_PORT_CFG = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_DIR_A = 8'h10;
    localparam logic [7:0] OFS_DIR_E = 8'h14;
    localparam logic [7:0] OFS_PORT_A = 8'h18;
    localparam logic [7:0] OFS_PORT_E = 8'h1C;
    // Control register A fields
    localparam int CTRL_POWER_BIT = 0;
    localparam int CTRL_GO_BIT = 2;
    localparam int CTRL_CHAN_LSB = 3;
    localparam int CTRL_CLKSEL_LSB = 6;
    // Status register fields
    localparam int STAT_FLAG_BIT = 0;
    localparam int STAT_BUSY_BIT = 1;
    localparam int STAT_PAUSE_BIT = 2;
    // Reset values
    localparam logic [5:0] DIR_A_RESET = 6'h3F;
    localparam logic [2:0] DIR_E_RESET = 3'h7;
    localparam logic [2:0] PORT_CFG_RESET = 3'h0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    // Conversion clock sources
    typedef enum logic [1:0] {
        ACS_CLK_OSC2 = 2'h0,
        ACS_CLK_OSC8 = 2'h1,
        ACS_CLK_OSC32 = 2'h2,
        ACS_CLK_RC = 2'h3
    } acs_clksel_e;
    // Timing: oscillator period and internal RC period in ns
    localparam int CLK_PERIOD_NS = 4;
    localparam int RC_PERIOD_NS = 4000;
    localparam int OSC2_MULT = 2;
    localparam int OSC8_MULT = 8;
    localparam int OSC32_MULT = 32;
    localparam int DIV_W = 10;
    // Half conversion-clock periods in oscillator cycles
    localparam logic [9:0] HALF_OSC2 = 10'(OSC2_MULT / 2);
    localparam logic [9:0] HALF_OSC8 = 10'(OSC8_MULT / 2);
    localparam logic [9:0] HALF_OSC32 = 10'(OSC32_MULT / 2);
    localparam logic [9:0] HALF_RC = 10'(RC_PERIOD_NS / (2 * CLK_PERIOD_NS));
    // Sequence lengths in half conversion-clock periods
    localparam logic [4:0] CONV_HALF_STEPS = 5'h13;
    localparam logic [4:0] HOLD_HALF_STEPS = 5'h03;
    localparam logic [4:0] PAUSE_HALF_STEPS = 5'h04;
    localparam logic [7:0] TRIAL_MSB = 8'h80;
    localparam logic [2:0] TRIAL_MSB_IDX = 3'h7;
    // Analog channel mask per port configuration code
    localparam logic [7:0] ANALOG_MASK [8] = '{
        8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00
    };
    // Sequencer states, Gray along idle-convert-pause
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_CONVERT = 2'b01,
        ACS_PAUSE = 2'b11
    } acs_state_e;
endpackage

/* File: logic/acs_tick_gen.sv */
// Conversion-clock half-period tick divider
`timescale 1ns/10ps
module acs_tick_gen (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [1:0] clock_select,
    input wire logic restart,
    output logic half_tick
);
    typedef struct packed {
        logic [9:0] count;
        logic tick;
    } acs_tick_s;

    acs_tick_s s;
    acs_tick_s next_s;
    logic [9:0] limit;

    // Reload length follows the select field every cycle
    // select field decode
    always_comb begin
        unique case (acs_pkg::acs_clksel_e'(clock_select))
            acs_pkg::ACS_CLK_OSC2: limit = acs_pkg::HALF_OSC2;
            acs_pkg::ACS_CLK_OSC8: limit = acs_pkg::HALF_OSC8;
            acs_pkg::ACS_CLK_OSC32: limit = acs_pkg::HALF_OSC32;
            acs_pkg::ACS_CLK_RC: limit = acs_pkg::HALF_RC;
        endcase
    end

    // Restart keeps the first step a full half period long
    always_comb begin
        next_s = s;
        if (restart || s.count >= limit - 10'h001) begin
            next_s.count = 10'h000;
        end else begin
            next_s.count = s.count + 10'h001;
        end
        next_s.tick = !restart && (s.count >= limit - 10'h001);
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign half_tick = s.tick;
endmodule // acs_tick_gen

/* File: logic/acs_sequencer.sv */
// Converter sequencer with APB registers and port readback
`timescale 1ns/10ps
module acs_sequencer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic comparator_in,
    input wire logic [5:0] port_a_pins,
    input wire logic [2:0] port_e_pins,
    output logic [7:0] dac_code,
    output logic holding_capacitor_connect,
    output logic [2:0] analog_channel,
    output logic converter_power_on,
    output logic [5:0] port_a_direction,
    output logic [2:0] port_e_direction,
    output logic conversion_done_irq_flag
);
    typedef struct packed {
        // Bus answer
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        // Software-visible registers
        logic power_on;
        logic go;
        logic [2:0] channel_select;
        logic [1:0] conv_clock_select;
        logic [2:0] port_config;
        logic [7:0] result;
        logic done_flag;
        logic [5:0] dir_a;
        logic [2:0] dir_e;
        // Sequencer
        acs_pkg::acs_state_e state;
        logic [4:0] step;
        logic [7:0] trial;
        logic [2:0] bit_idx;
        logic cap_connect;
        // Pin synchronisers
        logic comp_meta;
        logic comp_sync;
        logic [5:0] a_meta;
        logic [5:0] a_sync;
        logic [2:0] e_meta;
        logic [2:0] e_sync;
    } acs_state_s;

    acs_state_s s;
    acs_state_s next_s;
    logic half_tick;
    logic tick_restart;
    logic abort_req;
    logic [7:0] analog_mask;
    logic [5:0] analog_a;
    logic [5:0] port_a_read;
    logic [2:0] port_e_read;

    // Abort request seen while converting; the pause starts from it
    assign abort_req = (s.state == acs_pkg::ACS_CONVERT) && (!s.go || !s.power_on);

    // divider ticks
    // Held in restart while idle so each conversion starts on a fresh phase
    // restart on abort
    // Without it the pause after an abort could start mid-period and run short
    assign tick_restart = (s.state == acs_pkg::ACS_IDLE) || abort_req;

    // Divider reload follows the select field; the source decode lives inside it
    acs_tick_gen u_tick (
        .clock(clock),
        .rst_n(rst_n),
        .clock_select(s.conv_clock_select),
        .restart(tick_restart),
        .half_tick(half_tick)
    );

    // Port A bit order: AN0..AN3 on bits 0..3, bit 4 digital only, AN4 on bit 5
    assign analog_mask = acs_pkg::ANALOG_MASK[s.port_config];
    assign analog_a = {analog_mask[4], 1'b0, analog_mask[3:0]};

    // analog pins read zero
    // One gate per pin; direction bits play no part in the readback
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_port_a
            assign port_a_read[gi] = s.a_sync[gi] & ~analog_a[gi];
        end
    endgenerate
    assign port_e_read = s.e_sync & ~analog_mask[7:5];

    // Next-state logic: synchronisers, bus, sequencer
    always_comb begin
        logic setup;
        logic access;
        logic wr;
        logic mapped;
        logic [31:0] rd;
        logic [7:0] onehot;
        logic [7:0] resolved;
        logic [4:0] rel;
        logic done;
        setup = 1'b0;
        access = 1'b0;
        wr = 1'b0;
        mapped = 1'b0;
        rd = 32'h0000_0000;
        onehot = 8'h00;
        resolved = 8'h00;
        rel = 5'h00;
        done = 1'b0;
        next_s = s;

        // Two flops on every pin before use
        // The comparator answer reaches the sequencer three clocks after a new trial code,
        // so a bit time of two clocks (the 2 Tosc setting) resolves against a stale code;
        // that setting is below the minimum period anyway and gives no valid result
        next_s.comp_meta = comparator_in;
        next_s.comp_sync = s.comp_meta;
        next_s.a_meta = port_a_pins;
        next_s.a_sync = s.a_meta;
        next_s.e_meta = port_e_pins;
        next_s.e_sync = s.e_meta;

        // Address decode and read mux
        // Upper bits of every read word stay zero
        unique case (paddr)
            acs_pkg::OFS_CTRL_A: begin
                mapped = 1'b1;
                rd[acs_pkg::CTRL_POWER_BIT] = s.power_on;
                rd[acs_pkg::CTRL_GO_BIT] = s.go;
                rd[acs_pkg::CTRL_CHAN_LSB +: 3] = s.channel_select;
                rd[acs_pkg::CTRL_CLKSEL_LSB +: 2] = s.conv_clock_select;
            end
            acs_pkg::OFS_PORT_CFG: begin
                mapped = 1'b1;
                rd[2:0] = s.port_config;
            end
            acs_pkg::OFS_RESULT: begin
                mapped = 1'b1;
                rd[7:0] = s.result;
            end
            acs_pkg::OFS_STATUS: begin
                mapped = 1'b1;
                rd[acs_pkg::STAT_FLAG_BIT] = s.done_flag;
                rd[acs_pkg::STAT_BUSY_BIT] = (s.state == acs_pkg::ACS_CONVERT);
                rd[acs_pkg::STAT_PAUSE_BIT] = (s.state == acs_pkg::ACS_PAUSE);
            end
            acs_pkg::OFS_DIR_A: begin
                mapped = 1'b1;
                rd[5:0] = s.dir_a;
            end
            acs_pkg::OFS_DIR_E: begin
                mapped = 1'b1;
                rd[2:0] = s.dir_e;
            end
            acs_pkg::OFS_PORT_A: begin
                mapped = 1'b1;
                rd[5:0] = port_a_read;
            end
            acs_pkg::OFS_PORT_E: begin
                mapped = 1'b1;
                rd[2:0] = port_e_read;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase

        // Zero-wait APB: answer is prepared during the setup cycle
        // pready is a one-cycle pulse, so each setup earns exactly one answer
        // Unmapped offsets answer with pslverr and zero data; no register moves
        setup = psel && !penable;
        access = psel && penable && s.pready;
        wr = access && pwrite && mapped;
        next_s.pready = setup;
        next_s.pslverr = setup && !mapped;
        if (setup) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd;
        end

        // Successive-approximation sequencer
        // no interlocks
        // Channel and direction bits are never consulted here
        rel = s.step - acs_pkg::HOLD_HALF_STEPS;
        onehot = 8'h01 << s.bit_idx;
        // Trial code leaves on dac_code; its answer returns through the synchroniser
        // Comparator high keeps the trial bit
        resolved = s.comp_sync ? s.trial : (s.trial & ~onehot);
        unique case (s.state)
            acs_pkg::ACS_IDLE: begin
                if (s.power_on && s.go) begin
                    next_s.state = acs_pkg::ACS_CONVERT;
                    next_s.step = 5'h00;
                    next_s.trial = 8'h00;
                    next_s.bit_idx = acs_pkg::TRIAL_MSB_IDX;
                end
            end
            acs_pkg::ACS_CONVERT: begin
                if (abort_req) begin
                    next_s.state = acs_pkg::ACS_PAUSE;
                    next_s.step = 5'h00;
                end else if (half_tick) begin
                    next_s.step = s.step + 5'h01;
                    if (s.step == acs_pkg::HOLD_HALF_STEPS - 5'h01) begin
                        next_s.trial = acs_pkg::TRIAL_MSB;
                        next_s.bit_idx = acs_pkg::TRIAL_MSB_IDX;
                    end else if (s.step > acs_pkg::HOLD_HALF_STEPS && rel[0]) begin
                        if (s.step == acs_pkg::CONV_HALF_STEPS - 5'h01) begin
                            done = 1'b1;
                            next_s.trial = resolved;
                        end else begin
                            next_s.trial = resolved | (onehot >> 1);
                            next_s.bit_idx = s.bit_idx - 3'h1;
                        end
                    end
                end
            end
            acs_pkg::ACS_PAUSE: begin
                if (half_tick) begin
                    if (s.step == acs_pkg::PAUSE_HALF_STEPS - 5'h01) begin
                        next_s.state = acs_pkg::ACS_IDLE;
                        next_s.step = 5'h00;
                    end else begin
                        next_s.step = s.step + 5'h01;
                    end
                end
            end
            default: begin
                // Unused code falls back to idle
                next_s.state = acs_pkg::ACS_IDLE;
                next_s.step = 5'h00;
            end
        endcase

        // go clears on completion
        // The result moves only here or by a software write
        if (done) begin
            next_s.result = resolved;
            next_s.go = 1'b0;
            next_s.state = acs_pkg::ACS_PAUSE;
            next_s.step = 5'h00;
        end

        // Register writes; a software write to go lands after the done clear
        // Result is writable so software can seed the value that an abort leaves
        // Status has no writable bit apart from the flag clear below
        if (wr) begin
            unique case (paddr)
                acs_pkg::OFS_CTRL_A: begin
                    next_s.power_on = pwdata[acs_pkg::CTRL_POWER_BIT];
                    next_s.go = pwdata[acs_pkg::CTRL_GO_BIT];
                    next_s.channel_select = pwdata[acs_pkg::CTRL_CHAN_LSB +: 3];
                    next_s.conv_clock_select = pwdata[acs_pkg::CTRL_CLKSEL_LSB +: 2];
                end
                acs_pkg::OFS_PORT_CFG: next_s.port_config = pwdata[2:0];
                acs_pkg::OFS_RESULT: next_s.result = pwdata[7:0];
                acs_pkg::OFS_DIR_A: next_s.dir_a = pwdata[5:0];
                acs_pkg::OFS_DIR_E: next_s.dir_e = pwdata[2:0];
                default: begin
                    next_s.power_on = s.power_on;
                end
            endcase
        end

        // flag cleared only by software
        // Write one to clear; a completion in the same cycle wins
        if (wr && paddr == acs_pkg::OFS_STATUS && pwdata[acs_pkg::STAT_FLAG_BIT]) begin
            next_s.done_flag = 1'b0;
        end
        if (done) begin
            next_s.done_flag = 1'b1;
        end

        // whatever the pin drives is sampled
        // digital inputs also sampled
        // Tracking only while idle and powered, so it never charges mid-conversion
        // An abort reuses the same pause, so the capacitor stays off for it as well
        next_s.cap_connect = (next_s.state == acs_pkg::ACS_IDLE) && next_s.power_on;
    end

    // State register
    // Reset leaves the converter off and every pin direction an input
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s <= '0;
            s.dir_a <= acs_pkg::DIR_A_RESET;
            s.dir_e <= acs_pkg::DIR_E_RESET;
            s.port_config <= acs_pkg::PORT_CFG_RESET;
            s.result <= acs_pkg::RESULT_RESET;
            s.state <= acs_pkg::ACS_IDLE;
        end else begin
            s <= next_s;
        end
    end

    // Outputs straight from the state flops
    // Pin drivers live outside; only the direction bits leave this block
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign dac_code = s.trial;
    assign holding_capacitor_connect = s.cap_connect;
    assign analog_channel = s.channel_select;
    assign converter_power_on = s.power_on;
    assign port_a_direction = s.dir_a;
    assign port_e_direction = s.dir_e;
    assign conversion_done_irq_flag = s.done_flag;
endmodule // acs_sequencer

/* File: tb/acs_monitor.sv */
// Port-level assertions for the converter sequencer
`timescale 1ns/10ps
module acs_monitor (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic holding_capacitor_connect,
    input wire logic [2:0] analog_channel,
    input wire logic converter_power_on,
    input wire logic [5:0] port_a_direction,
    input wire logic conversion_done_irq_flag
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    logic [1:0] sel;
    logic [13:0] low_cnt;
    logic [13:0] half;
    logic ctrl_wr;
    logic stat_clr;
    // Bus decodes and half conversion period in clocks
    assign ctrl_wr = psel && penable && pready && pwrite && paddr == acs_pkg::OFS_CTRL_A;
    assign stat_clr = psel && penable && pready && pwrite && paddr == acs_pkg::OFS_STATUS && pwdata[0];
    assign half = (sel == 2'h3) ? 14'h01F4 : 14'h0001 << (2 * sel);
    // Count cycles with the capacitor off; the bench connects it before each start
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sel <= 2'h0;
            low_cnt <= 14'h0000;
        end else begin
            if (ctrl_wr) begin
                sel <= pwdata[7:6];
            end
            low_cnt <= holding_capacitor_connect ? 14'h0000 : low_cnt + 14'h0001;
        end
    end
    sequence s_done;
        $rose(conversion_done_irq_flag);
    endsequence
    sequence s_pause;
        !holding_capacitor_connect [*3];
    endsequence
    AST_PREADY_SETUP: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    AST_UNMAPPED: assert property (psel && !penable && paddr > 8'h1C |=> pslverr)
        else $error("unmapped access not refused");
    AST_DIR_RESET: assert property ($rose(rst_n) |-> port_a_direction == acs_pkg::DIR_A_RESET)
        else $error("direction reset value wrong");
    AST_GO_STARTS: assert property (ctrl_wr && pwdata[2] && pwdata[0] && holding_capacitor_connect |-> ##2 !holding_capacitor_connect)
        else $error("start did not release capacitor");
    AST_CONV_LENGTH: assert property (s_done |-> low_cnt >= 19 * half - 2 && low_cnt <= 19 * half + 3)
        else $error("conversion length wrong");
    AST_PAUSE_OPEN: assert property (s_done |-> s_pause)
        else $error("capacitor reconnected during pause");
    AST_DONE_STATE: assert property (s_done |-> converter_power_on && !holding_capacitor_connect)
        else $error("completion while unpowered or tracking");
    AST_FLAG_STICKY: assert property (conversion_done_irq_flag && !stat_clr |=> conversion_done_irq_flag)
        else $error("flag cleared by itself");
    AST_CHANNEL_FREE: assert property (ctrl_wr |=> analog_channel == $past(pwdata[5:3]))
        else $error("channel not taken");
endmodule // acs_monitor

/* File: tb/tb.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
module tb;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic comparator_in = 1'b0;
    logic [5:0] port_a_pins = 6'h00;
    logic [2:0] port_e_pins = 3'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] dac_code;
    logic holding_capacitor_connect;
    logic [2:0] analog_channel;
    logic converter_power_on;
    logic [5:0] port_a_direction;
    logic [2:0] port_e_direction;
    logic conversion_done_irq_flag;
    logic [7:0] vin = 8'h00;
    int num_errors = 0;
    int checked = 0;
    // Analog lanes AN7..AN0 per port configuration code
    logic [7:0] amask [8] = '{8'hFF, 8'hF7, 8'h1F, 8'h17, 8'h0B, 8'h03, 8'h00, 8'h00};
    acs_sequencer dut (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .comparator_in, .port_a_pins, .port_e_pins, .dac_code, .holding_capacitor_connect,
        .analog_channel, .converter_power_on, .port_a_direction, .port_e_direction,
        .conversion_done_irq_flag);
    always #2 clock = ~clock;
    // Ideal comparator: high while the input is at or above the trial code
    always @(posedge clock) comparator_in <= (vin >= dac_code);
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    // One transfer; request held until pready is seen high at an edge
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        n = 0;
        @(posedge clock);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk_rng("pready wait", 1, 1, n);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(a, 1'b1, d, q, e);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic e;
        apb(a, 1'b0, 32'h00000000, q, e);
        chk(nm, exp, q);
    endtask
    // Edges until the capacitor (cap=1) or the flag (cap=0) is high, bounded
    task automatic wait_on(input bit cap, input int lim, output int n);
        n = 0;
        while ((cap ? holding_capacitor_connect : conversion_done_irq_flag) !== 1'b1 && n < lim) begin
            @(posedge clock);
            n++;
        end
    endtask
    task automatic t_reset;
        logic [31:0] q;
        logic e;
        rd("dir a", acs_pkg::OFS_DIR_A, 32'h0000003F);
        rd("dir e", acs_pkg::OFS_DIR_E, 32'h00000007);
        chk("dir e pin", 32'h00000007, {29'h0, port_e_direction});
        rd("port cfg", acs_pkg::OFS_PORT_CFG, 32'h00000000);
        rd("control", acs_pkg::OFS_CTRL_A, 32'h00000000);
        rd("status", acs_pkg::OFS_STATUS, 32'h00000000);
        wr(acs_pkg::OFS_RESULT, 32'h000000C3);
        rd("result rw", acs_pkg::OFS_RESULT, 32'h000000C3);
        apb(8'h20, 1'b0, 32'h00000000, q, e);
        chk("unmapped err", 32'h00000001, {31'h0, e});
        chk("unmapped data", 32'h00000000, q);
    endtask
    task automatic t_ports;
        logic [7:0] m;
        port_a_pins <= 6'h3F;
        port_e_pins <= 3'h7;
        for (int c = 0; c < 8; c++) begin
            m = amask[c];
            wr(acs_pkg::OFS_PORT_CFG, 32'(c));
            rd("port a", acs_pkg::OFS_PORT_A, {26'h0, ~m[4], 1'b1, ~m[3:0]});
            rd("port e", acs_pkg::OFS_PORT_E, {29'h0, ~m[7:5]});
        end
    endtask
    // Full conversion; the fixed wait stands for the acquisition time
    task automatic t_conv(input logic [1:0] sel, input logic [7:0] v, input logic [2:0] ch);
        logic [31:0] c;
        int h;
        int n;
        c = {24'h0, sel, ch, 3'h1};
        h = (sel == 2'h3) ? 500 : 1 << (2 * sel);
        vin <= v;
        wr(acs_pkg::OFS_DIR_A, {26'h0, {6{ch[0]}} ^ 6'h3F});
        wr(acs_pkg::OFS_CTRL_A, c);
        wait_on(1'b1, 50, n);
        repeat (20) @(posedge clock);
        chk("dir a pin", {26'h0, {6{ch[0]}} ^ 6'h3F}, {26'h0, port_a_direction});
        wr(acs_pkg::OFS_CTRL_A, c | 32'h4);
        wait_on(1'b0, 20 * h + 20, n);
        chk_rng("conv cycles", 19 * h - 1, 19 * h + 3, n);
        wait_on(1'b1, 4 * h + 20, n);
        chk_rng("pause cycles", 4 * h - 1, 4 * h + 3, n);
        chk("dac code", {24'h0, v}, {24'h0, dac_code});
        rd("go cleared", acs_pkg::OFS_CTRL_A, c);
        rd("result", acs_pkg::OFS_RESULT, {24'h0, v});
        rd("flag kept", acs_pkg::OFS_STATUS, 32'h1);
        wr(acs_pkg::OFS_STATUS, 32'h1);
        rd("flag cleared", acs_pkg::OFS_STATUS, 32'h0);
    endtask
    task automatic t_abort;
        int n;
        vin <= 8'h11;
        wr(acs_pkg::OFS_CTRL_A, 32'h00000084);
        repeat (40) @(posedge clock);
        chk("no start", 32'h0, {31'h0, conversion_done_irq_flag});
        rd("go held", acs_pkg::OFS_CTRL_A, 32'h84);
        wr(acs_pkg::OFS_CTRL_A, 32'h00000081);
        wait_on(1'b1, 50, n);
        repeat (20) @(posedge clock);
        wr(acs_pkg::OFS_CTRL_A, 32'h00000085);
        repeat (100) @(posedge clock);
        wr(acs_pkg::OFS_CTRL_A, 32'h00000081);
        wait_on(1'b1, 100, n);
        chk_rng("abort pause", 63, 68, n);
        chk("no flag", 32'h0, {31'h0, conversion_done_irq_flag});
        rd("result kept", acs_pkg::OFS_RESULT, 32'h5A);
    endtask
    // Reset, then every clock source; ports stay all digital from the scan
    initial begin
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        t_reset;
        t_ports;
        // 2 Tosc is shorter than the comparator settle, so only an all-ones input is exact there
        t_conv(2'h0, 8'hFF, 3'h0);
        t_conv(2'h1, 8'h3C, 3'h7);
        t_conv(2'h2, 8'hA5, 3'h2);
        t_conv(2'h3, 8'h5A, 3'h5);
        t_abort;
        close_out;
    end
    // Watchdog well beyond the roughly 12500 cycles the run needs
    initial begin
        #200000;
        num_errors++;
        close_out;
    end
endmodule // tb
bind acs_sequencer acs_monitor mon (.clock, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .pslverr, .holding_capacitor_connect, .analog_channel, .converter_power_on, .port_a_direction,
    .conversion_done_irq_flag);
